// File: hdl/bsp_top.sv
`timescale 1ns/100ps
`default_nettype none
//Behaviour
// - clock select 000-101 internal divider, 111 external pin, 110 unused
// - codes 001-101 divide by 256..16; 000 by 8192 or low clock by 32
// - internal clock drives sck pin out; pin high when transfer starts
// - transmitted data change on serial clock falling edge
// - received data sampled on serial clock rising edge
// - 4-bit mode uses low nibble, stores zero upper nibble; LSB first
// - one to eight words back to back, then completion interrupt
// - shift register reloads from buffer once current word is out
// - transmit completion interrupt after last word of the count
// - internal transmit waits with clock stopped until buffer written
// - a write to any buffer entry releases the transmit wait
// - clearing run finishes the current word, then ends, clears active
// - abort ends transfer at once and clears active flag
// - external transmit not stopped in time sends dummy word then ends
// - receive stores each word in next entry, interrupt when count full
// - internal receive waits with clock stopped until any buffer read
// - external receive with unread data drops new word and ends
// - clearing run in receive stores current word, then ends
// - changing transfer mode clears the buffer
// - mode codes 000,010,100,101,110; others reserved
// - word count 000-111 selects one to eight words from entry zero
// - buffer entries used in ascending order from lowest
// - status shows transfer active and shift active flags
module bsp_top (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic      [1:0]  bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp,
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe,
    input  wire logic        si,
    output logic             so,
    input  wire logic        lf_clk,
    output logic             transfer_done_irq
);
    logic [7:0]  ctl1_r, ctl2_r, aw_r, ar_r, wd_r, rx_sh_r, ext_dat;
    logic [6:0]  tx_sh_r;
    logic [2:0]  sy1_r, sy2_r, syd_r, idx_r, bit_r, nbit_m1;
    logic [12:0] div_r, half;
    logic [7:0]  mem_rd_a, mem_rd_b, mem_wd;
    logic        wst_r, abort_r, rph1_r, rph2_r, svc_r, last_r;
    logic        do_wr, eng_we, mem_clr, buf_acc, serviced, ext, use_lf, step;
    logic        tick, rise, fall, word_end, done, start, is_tx, is_rx, nib, ok_mode;
    bsp_pkg::bsp_state_e st_r;

    wire [2:0] mode = ctl1_r[bsp_pkg::C1_MODE +: 3];
    wire [2:0] csel = ctl1_r[bsp_pkg::C1_CLK +: 3];
    wire [2:0] wcnt = ctl2_r[bsp_pkg::C2_CNT +: 3];
    wire       run  = ctl1_r[bsp_pkg::C1_RUN];
    wire       si_s = sy2_r[0];

    // mode decode
    always_comb
    begin
        is_tx = (mode == bsp_pkg::MODE_TX8) || (mode == bsp_pkg::MODE_TX4)
             || (mode == bsp_pkg::MODE_TRX8);
        is_rx = (mode == bsp_pkg::MODE_RX8) || (mode == bsp_pkg::MODE_RX4)
             || (mode == bsp_pkg::MODE_TRX8);
        nib     = (mode == bsp_pkg::MODE_TX4) || (mode == bsp_pkg::MODE_RX4);
        ok_mode = is_tx || is_rx;
        nbit_m1 = nib ? 3'h3 : 3'h7;
        ext     = (csel == bsp_pkg::CLK_EXT);
    end

    // bus write side: address and data taken in either order
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= 2'h0;
            aw_r    <= 8'h00;
            wd_r    <= 8'h00;
            wst_r   <= 1'b0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                awready <= 1'b0;
                aw_r    <= awaddr;
            end
            if (wvalid && wready)
            begin
                wready <= 1'b0;
                wd_r   <= wdata[7:0];
                wst_r  <= wstrb[0];
            end
            if (do_wr)
            begin
                bvalid <= 1'b1;
                bresp  <= (aw_r[7:5] == bsp_pkg::BUF_HI || aw_r == bsp_pkg::ADDR_CTRL1
                        || aw_r == bsp_pkg::ADDR_CTRL2) ? 2'h0 : 2'h2;
            end
            else if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // a bus write yields to a receive store in the same cycle
    assign do_wr   = !awready && !wready && !bvalid && !eng_we;
    assign mem_clr = do_wr && wst_r && aw_r == bsp_pkg::ADDR_CTRL1
                  && wd_r[bsp_pkg::C1_MODE +: 3] != mode;
    assign buf_acc = (do_wr && aw_r[7:5] == bsp_pkg::BUF_HI)
                  || (rph2_r && ar_r[7:5] == bsp_pkg::BUF_HI);

    // control registers; abort bit self clears after one cycle
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl1_r  <= bsp_pkg::CTRL1_RST;
            ctl2_r  <= bsp_pkg::CTRL2_RST;
            abort_r <= 1'b0;
        end
        else
        begin
            abort_r <= do_wr && wst_r && aw_r == bsp_pkg::ADDR_CTRL1
                    && wd_r[bsp_pkg::C1_ABORT];
            if (do_wr && wst_r && aw_r == bsp_pkg::ADDR_CTRL1)
                ctl1_r <= wd_r & ~(8'h01 << bsp_pkg::C1_ABORT);
            else if (word_end && last_r && ext)
                ctl1_r[bsp_pkg::C1_RUN] <= 1'b0;
            if (do_wr && wst_r && aw_r == bsp_pkg::ADDR_CTRL2)
                ctl2_r <= wd_r;
        end
    end

    // bus read side: two cycles from address to data
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= 2'h0;
            ar_r    <= 8'h00;
            rph1_r  <= 1'b0;
            rph2_r  <= 1'b0;
        end
        else
        begin
            rph1_r <= arvalid && arready;
            rph2_r <= rph1_r;
            if (arvalid && arready)
            begin
                arready <= 1'b0;
                ar_r    <= araddr;
            end
            if (rph2_r)
            begin
                rvalid <= 1'b1;
                rresp  <= 2'h0;
                if (ar_r[7:5] == bsp_pkg::BUF_HI)
                    rdata <= {24'h00_0000, mem_rd_a};
                else if (ar_r == bsp_pkg::ADDR_STAT)
                    rdata <= {24'h00_0000, (st_r != bsp_pkg::BSP_IDLE),
                              (st_r == bsp_pkg::BSP_SHIFT), 6'h00};
                else
                begin
                    rdata <= 32'h0000_0000;
                    if (ar_r != bsp_pkg::ADDR_CTRL1 && ar_r != bsp_pkg::ADDR_CTRL2)
                        rresp <= 2'h2;
                end
            end
            else if (rvalid && rready)
            begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // pin synchronisers: bit0 si, bit1 sck, bit2 low clock
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sy1_r <= 3'h2;
            sy2_r <= 3'h2;
            syd_r <= 3'h2;
        end
        else
        begin
            sy1_r <= {lf_clk, sck_i, si};
            sy2_r <= sy1_r;
            syd_r <= sy2_r;
        end
    end

    // internal rate select, half period counts
    always_comb
    begin
        use_lf = (csel == 3'h0) && ctl2_r[bsp_pkg::C2_TAP];
        case (csel)
            3'h0:    half = use_lf ? 13'(bsp_pkg::DIV_LF / 2) : 13'(bsp_pkg::DIV_0 / 2);
            3'h1:    half = 13'(bsp_pkg::DIV_1 / 2);
            3'h2:    half = 13'(bsp_pkg::DIV_2 / 2);
            3'h3:    half = 13'(bsp_pkg::DIV_3 / 2);
            3'h4:    half = 13'(bsp_pkg::DIV_4 / 2);
            3'h5:    half = 13'(bsp_pkg::DIV_5 / 2);
            default: half = 13'h1000;
        endcase
        step = use_lf ? (sy2_r[2] && !syd_r[2]) : 1'b1;
    end

    // divider runs only while shifting, held at zero during automatic wait
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            div_r <= 13'h0000;
        else if (st_r != bsp_pkg::BSP_SHIFT || ext)
            div_r <= 13'h0000;
        else if (step)
            div_r <= (div_r >= half - 13'h0001) ? 13'h0000 : div_r + 13'h0001;
    end

    // serial clock edges from divider or synchronised pin
    always_comb
    begin
        tick = (st_r == bsp_pkg::BSP_SHIFT) && !ext && step
            && (div_r >= half - 13'h0001);
        if (ext)
        begin
            rise = (st_r == bsp_pkg::BSP_SHIFT) && sy2_r[1] && !syd_r[1];
            fall = (st_r == bsp_pkg::BSP_SHIFT) && !sy2_r[1] && syd_r[1];
        end
        else
        begin
            rise = tick && !sck_o;
            fall = tick && sck_o;
        end
        word_end = rise && (bit_r == nbit_m1);
        done     = word_end && (idx_r == wcnt);
        start    = (st_r == bsp_pkg::BSP_IDLE) && run && ok_mode && !abort_r
                && (csel != bsp_pkg::CLK_UNUSED);
        serviced = svc_r || buf_acc;
        ext_dat  = nib ? {4'h0, si_s, rx_sh_r[7:5]} : {si_s, rx_sh_r[7:1]};
    end

    assign eng_we = word_end && is_rx && !(last_r && ext);
    assign mem_wd = ext_dat;

    // transfer sequencer
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= bsp_pkg::BSP_IDLE;
        else
        begin
            case (st_r)
                bsp_pkg::BSP_IDLE:
                    if (start)
                        st_r <= bsp_pkg::BSP_SHIFT;
                bsp_pkg::BSP_SHIFT:
                    if (abort_r)
                        st_r <= bsp_pkg::BSP_IDLE;
                    else if (word_end && last_r && ext)
                        st_r <= bsp_pkg::BSP_IDLE;
                    else if (word_end && !run)
                        st_r <= bsp_pkg::BSP_IDLE;
                    else if (done && !serviced && !ext)
                        st_r <= bsp_pkg::BSP_HOLD;
                bsp_pkg::BSP_HOLD:
                    if (abort_r || !run)
                        st_r <= bsp_pkg::BSP_IDLE;
                    else if (buf_acc)
                        st_r <= bsp_pkg::BSP_SHIFT;
                default:
                    st_r <= bsp_pkg::BSP_IDLE;
            endcase
        end
    end

    // service and last-word flags; an access in the clearing cycle wins
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            svc_r  <= 1'b0;
            last_r <= 1'b0;
        end
        else
        begin
            svc_r <= (buf_acc && st_r != bsp_pkg::BSP_HOLD)
                  || (svc_r && !done && !start && st_r != bsp_pkg::BSP_HOLD);
            if (start)
                last_r <= 1'b0;
            else if (done && !serviced && ext)
                last_r <= 1'b1;
        end
    end

    // word and bit counters, ascending buffer entries
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            idx_r <= 3'h0;
            bit_r <= 3'h0;
        end
        else if (start)
        begin
            idx_r <= 3'h0;
            bit_r <= 3'h0;
        end
        else if (rise)
        begin
            bit_r <= word_end ? 3'h0 : bit_r + 3'h1;
            if (word_end)
                idx_r <= done ? 3'h0 : idx_r + 3'h1;
        end
    end

    // shifting, LSB first; reload at start of each word
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            so      <= 1'b1;
            tx_sh_r <= 7'h00;
            rx_sh_r <= 8'h00;
        end
        else
        begin
            if (fall && is_tx)
            begin
                if (bit_r == 3'h0)
                begin
                    so      <= mem_rd_b[0];
                    tx_sh_r <= mem_rd_b[7:1];
                end
                else
                begin
                    so      <= tx_sh_r[0];
                    tx_sh_r <= {1'b0, tx_sh_r[6:1]};
                end
            end
            if (rise && is_rx)
                rx_sh_r <= {si_s, rx_sh_r[7:1]};
        end
    end

    // serial clock pin, interrupt pulse
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sck_o             <= 1'b1;
            sck_oe            <= 1'b0;
            transfer_done_irq <= 1'b0;
        end
        else
        begin
            sck_oe <= !ext && (csel != bsp_pkg::CLK_UNUSED);
            if (st_r == bsp_pkg::BSP_IDLE)
                sck_o <= 1'b1;
            else if (tick)
                sck_o <= !sck_o;
            transfer_done_irq <= done && !(last_r && ext);
        end
    end

    bsp_buf_mem u_mem (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .clr     (mem_clr),
        .we      (eng_we || do_wr && wst_r && aw_r[7:5] == bsp_pkg::BUF_HI),
        .waddr   (eng_we ? idx_r : aw_r[4:2]),
        .wdata   (eng_we ? mem_wd : wd_r),
        .raddr_a (ar_r[4:2]),
        .raddr_b (idx_r),
        .rdata_a (mem_rd_a),
        .rdata_b (mem_rd_b)
    );

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_word_done;
        done && !(last_r && ext);
    endsequence
    sequence s_abort_req;
        abort_r && st_r != bsp_pkg::BSP_IDLE;
    endsequence

    a_irq_single: assert property (s_word_done |=> transfer_done_irq ##1 !transfer_done_irq)
        else $error("done irq not a single pulse");
    a_abort_ends: assert property (s_abort_req |=> st_r == bsp_pkg::BSP_IDLE)
        else $error("abort did not end transfer");
    a_ext_nodrive: assert property (ext |=> !sck_oe)
        else $error("sck driven under external clock");
    a_idle_high: assert property (st_r == bsp_pkg::BSP_IDLE |=> sck_o)
        else $error("sck not high while idle");
    a_hold_still: assert property (st_r == bsp_pkg::BSP_HOLD |=> $stable(sck_o) && sck_o)
        else $error("serial clock moved during wait");
    a_tx_load: assert property (fall && is_tx && bit_r == 3'h0 |=> so == $past(mem_rd_b[0]))
        else $error("first bit not lsb of entry");
    a_rx_sample: assert property (rise && is_rx |=> rx_sh_r[7] == $past(si_s))
        else $error("rx bit not taken on rising edge");
    a_nib_zero: assert property (eng_we && nib |-> mem_wd[7:4] == 4'h0)
        else $error("upper nibble not zero");
    a_idx_wrap: assert property (done |=> idx_r == 3'h0)
        else $error("word index did not wrap");
    a_stop_end: assert property (word_end && !run && !abort_r
                                 |=> st_r == bsp_pkg::BSP_IDLE)
        else $error("run clear did not end at word");
endmodule : bsp_top
`default_nettype wire

// File: hdl/bsp_pkg.sv
package bsp_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL1 = 8'h00;
    localparam logic [7:0] ADDR_CTRL2 = 8'h04;
    localparam logic [7:0] ADDR_STAT  = 8'h08;
    localparam logic [7:0] ADDR_BUF   = 8'h20;
    localparam logic [2:0] BUF_HI     = 3'h1;   // addr[7:5] of buffer window

    // serial_control_one fields
    localparam int C1_RUN    = 7;
    localparam int C1_ABORT  = 6;
    localparam int C1_MODE   = 3;
    localparam int C1_CLK    = 0;
    // serial_control_two fields
    localparam int C2_TAP    = 7;
    localparam int C2_WAIT   = 3;
    localparam int C2_CNT    = 0;
    // serial_status_reg fields
    localparam int ST_ACTIVE = 7;
    localparam int ST_SHIFT  = 6;

    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;

    // transfer_mode_select codes
    localparam logic [2:0] MODE_TX8  = 3'h0;
    localparam logic [2:0] MODE_TX4  = 3'h2;
    localparam logic [2:0] MODE_TRX8 = 3'h4;
    localparam logic [2:0] MODE_RX8  = 3'h5;
    localparam logic [2:0] MODE_RX4  = 3'h6;
    // clock select codes
    localparam logic [2:0] CLK_UNUSED = 3'h6;
    localparam logic [2:0] CLK_EXT    = 3'h7;

    // serial clock dividers, full period in source clocks
    localparam int DIV_0  = 8192;
    localparam int DIV_1  = 256;
    localparam int DIV_2  = 128;
    localparam int DIV_3  = 64;
    localparam int DIV_4  = 32;
    localparam int DIV_5  = 16;
    localparam int DIV_LF = 32;

    typedef enum logic [1:0] {BSP_IDLE, BSP_SHIFT, BSP_HOLD} bsp_state_e;
endpackage : bsp_pkg

// File: hdl/bsp_buf_mem.sv
`timescale 1ns/100ps
`default_nettype none
// eight byte data_buffer, two registered read ports, clear on mode change
module bsp_buf_mem (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       clr,
    input  wire logic       we,
    input  wire logic [2:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [2:0] raddr_a,
    input  wire logic [2:0] raddr_b,
    output logic      [7:0] rdata_a,
    output logic      [7:0] rdata_b
);
    logic [7:0] mem_r [0:7];

    // storage; clear wins over write
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 8; i++)
                mem_r[i] <= 8'h00;
        end
        else if (clr)
        begin
            for (int i = 0; i < 8; i++)
                mem_r[i] <= 8'h00;
        end
        else if (we)
            mem_r[waddr] <= wdata;
    end

    // registered read ports
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_a <= 8'h00;
            rdata_b <= 8'h00;
        end
        else
        begin
            rdata_a <= mem_r[raddr_a];
            rdata_b <= mem_r[raddr_b];
        end
    end
endmodule : bsp_buf_mem
`default_nettype wire

// File: tb/bsp_peer.sv
`timescale 1ns/100ps
`default_nettype none
// far-side serial peer, one 16-bit frame of two words
module bsp_peer (
    input  wire logic        sck,
    input  wire logic        so,
    input  wire logic        clr,
    input  wire logic [15:0] tx,
    output logic             si,
    output logic      [15:0] rx
);
    int idx = 0;

    // restart the frame
    always @(posedge clr)
    begin
        idx = 0;
        rx = 16'h0000;
    end

    // launch on the falling edge, lsb first; scramble once the frame is out
    always @(negedge sck)
    begin
        si <= (idx < 16) ? tx[idx[3:0]] : ~si;
    end

    // capture on the rising edge, lsb first
    always @(posedge sck)
    begin
        rx <= {so, rx[15:1]};
        idx <= idx + 1;
    end
endmodule : bsp_peer
`default_nettype wire

// File: tb/bsp_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module bsp_top_tb;
    logic        mclk, rst_n, awvalid, wvalid, bready, arvalid, rready, sck_i, pclr, lf_clk;
    logic        awready, wready, bvalid, arready, rvalid, sck_o, sck_oe, si, so, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd_val;
    logic [1:0]  bresp, rresp, rd_resp, wr_resp;
    logic [15:0] ptx, prx;
    int          fail_count, checks;
    wire logic   sck_wire;

    // pin level seen by the peer
    assign sck_wire = sck_oe ? sck_o : sck_i;

    // system clock
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // low-frequency clock, toggled every system clock
    always @(posedge mclk)
        lf_clk <= ~lf_clk;

    bsp_top dut (.mclk(mclk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe),
        .si(si), .so(so), .lf_clk(lf_clk), .transfer_done_irq(irq));

    bsp_peer peer (.sck(sck_wire), .so(so), .clr(pclr), .tx(ptx), .si(si), .rx(prx));

    task test_done;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    task bound(input int n, input int lim);
        if (n >= lim)
        begin
            fail_count++;
            test_done;
        end
    endtask : bound

    task wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge mclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h000000, d};
        bready <= 1'b1;
        for (n = 0; n < 200; n++)
        begin
            @(posedge mclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        bready <= 1'b0;
        wr_resp = bresp;
        bound(n, 200);
    endtask : wr

    task rd(input logic [7:0] a);
        int n;
        @(posedge mclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (n = 0; n < 200; n++)
        begin
            @(posedge mclk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        rready <= 1'b0;
        rd_val = rdata;
        rd_resp = rresp;
        bound(n, 200);
    endtask : rd

    // completion pulse, then one cycle low
    task wait_irq;
        int n;
        for (n = 0; n < 4000; n++)
        begin
            @(posedge mclk);
            if (irq === 1'b1)
                break;
        end
        bound(n, 4000);
        @(posedge mclk);
        `CHK(irq, 1'b0)
    endtask : wait_irq

    // external clock, eight system clocks per level
    task ext_clk(input int bits);
        repeat (bits)
        begin
            repeat (8) @(posedge mclk);
            sck_i <= 1'b0;
            repeat (8) @(posedge mclk);
            sck_i <= 1'b1;
        end
    endtask : ext_clk

    task peer_clr(input logic [15:0] t);
        pclr <= 1'b1;
        ptx <= t;
        @(posedge mclk);
        pclr <= 1'b0;
    endtask : peer_clr

    task t_reset;
        `CHK({sck_o, so, sck_oe, irq}, 4'hc)
        rd(8'h08);
        `CHK(rd_val, 32'h0)
        rd(8'h40);
        `CHK(rd_resp, 2'h2)
        wr(8'h40, 8'h11);
        `CHK(wr_resp, 2'h2)
    endtask : t_reset

    // two words out on the internal clock, then hold, then abort
    task t_tx8;
        peer_clr(16'hffff);
        wr(8'h04, 8'h01);
        wr(8'h20, 8'ha5);
        wr(8'h24, 8'h3c);
        wr(8'h00, 8'h05);
        wr(8'h00, 8'h85);
        `CHK(sck_oe, 1'b1)
        rd(8'h08);
        `CHK(rd_val[7], 1'b1)
        wait_irq;
        `CHK(prx, 16'h3ca5)
        repeat (40) @(posedge mclk);
        `CHK(sck_o, 1'b1)
        rd(8'h08);
        `CHK(rd_val[7:6], 2'h2)
        wr(8'h3c, 8'h00);
        rd(8'h08);
        `CHK(rd_val[7:6], 2'h3)
        wr(8'h00, 8'h45);
        rd(8'h08);
        `CHK(rd_val[7], 1'b0)
    endtask : t_tx8

    // one nibble in on the internal clock, then mode change clears buffer
    task t_rx4;
        wr(8'h04, 8'h00);
        wr(8'h00, 8'h35);
        peer_clr(16'h00f9);
        wr(8'h00, 8'hb5);
        wait_irq;
        wr(8'h00, 8'h75);
        rd(8'h20);
        `CHK(rd_val, 32'h09)
        wr(8'h24, 8'h77);
        wr(8'h00, 8'h2f);
        rd(8'h24);
        `CHK(sck_oe, 1'b0)
        `CHK(rd_val, 32'h0)
    endtask : t_rx4

    // one byte in on the external clock
    task t_rx_ext;
        peer_clr(16'h0096);
        wr(8'h00, 8'haf);
        ext_clk(8);
        repeat (8) @(posedge mclk);
        ext_clk(8);
        repeat (8) @(posedge mclk);
        rd(8'h08);
        `CHK(rd_val[7], 1'b0)
        rd(8'h20);
        `CHK(rd_val, 32'h96)
        wr(8'h00, 8'h6f);
        rd(8'h08);
        `CHK(rd_val[7], 1'b0)
    endtask : t_rx_ext

    // one byte out on the external clock, no reload, so a dummy word ends it
    task t_tx_ext;
        wr(8'h00, 8'h07);
        wr(8'h20, 8'h5a);
        peer_clr(16'h0000);
        wr(8'h00, 8'h87);
        ext_clk(8);
        repeat (8) @(posedge mclk);
        rd(8'h08);
        `CHK(rd_val[7], 1'b1)
        ext_clk(8);
        repeat (8) @(posedge mclk);
        rd(8'h08);
        `CHK(rd_val[7], 1'b0)
        `CHK(prx[7:0], 8'h5a)
    endtask : t_tx_ext

    // one nibble out on the divided low clock
    task t_lf;
        wr(8'h04, 8'h80);
        wr(8'h00, 8'h10);
        wr(8'h20, 8'h81);
        peer_clr(16'h0000);
        wr(8'h00, 8'h90);
        repeat (20) @(posedge mclk);
        `CHK(sck_o, 1'b1)
        repeat (20) @(posedge mclk);
        `CHK(sck_o, 1'b0)
        wait_irq;
        `CHK(prx, 16'h1000)
        wr(8'h00, 8'h50);
    endtask : t_lf

    // reserved mode never starts
    task t_reserved;
        wr(8'h00, 8'h3d);
        wr(8'h00, 8'hbd);
        repeat (20) @(posedge mclk);
        rd(8'h08);
        `CHK(rd_val[7], 1'b0)
        `CHK(sck_o, 1'b1)
    endtask : t_reserved

    // main sequence
    initial
    begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready, pclr, lf_clk} = 8'h00;
        {awaddr, araddr, wdata, ptx, sck_i} = 65'h1;
        fail_count = 0;
        checks = 0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset;
        t_tx8;
        t_rx4;
        t_rx_ext;
        t_tx_ext;
        t_lf;
        t_reserved;
        test_done;
    end
endmodule : bsp_top_tb
`default_nettype wire
